// file: bench/sfc_frame_ctrl_bench.sv
/* Bench for the serial frame control with a behavioural model.
   Assumes the host model and the bound port checker. */
`timescale 1ns/10ps
module sfc_frame_ctrl_bench;
  import sfc_pkg::*;
  logic clk_sys, arst_n, trim_seen, prev_ok, first_fr;
  wire cs_n_pin, sclk_pin;
  logic sdo_out, sdo_oe, acquire_state, convert_state;
  logic offset_trim_state, trim_done;
  logic signed [15:0] pos_in, neg_in;
  logic [64:0] got;
  logic [13:0] prev;
  int bad_count, n_compared, seed;
  int n_tab[8] = '{18, 18, 20, 10, 18, 40, 64, 24};
  int d_tab[8] = '{0, 8191, -9000, 1, -8191, -1, 8190, 20000};
  sfc_frame_ctrl dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .positive_input(pos_in), .negative_input(neg_in),
    .acquire_state(acquire_state), .convert_state(convert_state),
    .offset_trim_state(offset_trim_state), .trim_done(trim_done));
  sfc_host_model host_u (.cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe));
  function automatic logic [13:0] code_of(int v);
    if (v >= 8191) return 14'h1FFF;
    if (v <= -8191) return 14'h2000;
    return v[13:0];
  endfunction
  task automatic chk(input logic [64:0] g, input logic [64:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One frame: expected bits come from the previous conversion
  task automatic run_frame(input int n, input int dv, input int p);
    logic [64:0] e;
    pos_in = 16'(p);
    neg_in = 16'(p - dv);
    repeat (5) @(posedge clk_sys);
    host_u.frame(n, got);
    e = '0;
    for (int i = 1; i <= 14 && i <= n; i++) e[n - i] = prev[14 - i];
    if (prev_ok) chk(got, e);
    prev = code_of(dv);
    prev_ok = (n >= 18);
    trim_seen = trim_seen | (n >= 64) | (first_fr && n >= 24);
    first_fr = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    chk({62'h0, acquire_state, sdo_oe, trim_done},
      {62'h0, 1'b1, 1'b0, trim_seen});
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    #1000000;
    bad_count++;
    give_verdict();
  end
  initial begin
    arst_n = 1'b0;
    pos_in = 16'h0000;
    neg_in = 16'h0000;
    trim_seen = 1'b0;
    prev_ok = 1'b1;
    first_fr = 1'b1;
    prev = 14'h0000;
    seed = 32'hF4FE0A72;
    repeat (6) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    chk({64'h0, acquire_state}, 65'h1);
    repeat (4) @(posedge clk_sys);
    #1;
    for (int i = 0; i < 8; i++) run_frame(n_tab[i], d_tab[i], d_tab[i] / 2);
    for (int i = 0; i < 6; i++) begin
      run_frame(18, $random(seed) % 16000, $random(seed) % 8000);
    end
    run_frame(18, 0, 0);
    // Second power-up, then offset trim in its first frame
    arst_n = 1'b0;
    prev = 14'h0000;
    prev_ok = 1'b1;
    first_fr = 1'b1;
    trim_seen = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    chk({63'h0, acquire_state, trim_done}, 65'h2);
    repeat (4) @(posedge clk_sys);
    #1;
    run_frame(24, 100, 50);
    run_frame(18, 5, 0);
    give_verdict();
  end
endmodule

// file: bench/sfc_frame_props.sv
/* Port checker for the serial frame control.
   Assumes it is bound to sfc_frame_ctrl and sees its ports only. */
`timescale 1ns/10ps
module sfc_frame_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Link
  input wire logic cs_n_pin,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  // Status
  input wire logic acquire_state,
  input wire logic convert_state,
  input wire logic offset_trim_state,
  input wire logic trim_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_cs_high; cs_n_pin [*4]; endsequence
  sequence s_cs_low; !cs_n_pin [*4]; endsequence
  property p_oe_off; s_cs_high |-> !sdo_oe; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("data line driven while deselected");
  property p_oe_on; s_cs_low |-> sdo_oe; endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("data line not driven in frame");
  property p_lead; $rose(sdo_oe) |-> ##2 !sdo_out; endproperty
  a_lead: assert property (p_lead)
    else $error("no leading zero");
  property p_conv; $fell(cs_n_pin) |-> ##[2:6] convert_state; endproperty
  a_conv: assert property (p_conv)
    else $error("frame start did not convert");
  property p_onehot;
    $onehot({acquire_state, convert_state, offset_trim_state});
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("state not one-hot");
  property p_idle; s_cs_high |-> acquire_state; endproperty
  a_idle: assert property (p_idle)
    else $error("not acquiring between frames");
  property p_trim_rise; $rose(trim_done) |-> $past(offset_trim_state);
  endproperty
  a_trim_rise: assert property (p_trim_rise)
    else $error("trim done without trim state");
  property p_trim_exit; $fell(offset_trim_state) |-> acquire_state;
  endproperty
  a_trim_exit: assert property (p_trim_exit)
    else $error("trim left to wrong state");
  property p_rst; $rose(arst_n) |-> acquire_state; endproperty
  a_rst: assert property (p_rst)
    else $error("not acquiring after reset");
endmodule
bind sfc_frame_ctrl sfc_frame_props props_u (.clk_sys(clk_sys),
  .arst_n(arst_n), .cs_n_pin(cs_n_pin), .sdo_out(sdo_out),
  .sdo_oe(sdo_oe), .acquire_state(acquire_state),
  .convert_state(convert_state), .offset_trim_state(offset_trim_state),
  .trim_done(trim_done));

// file: bench/sfc_host_model.sv
/* Host side of the link: chip select, serial clock, data sampling.
   Assumes an 80 ns half period of the serial clock. */
`timescale 1ns/10ps
module sfc_host_model (
  // Link outputs
  output logic cs_n_pin,
  output logic sclk_pin,
  // Data from the device
  input wire logic sdo_out,
  input wire logic sdo_oe
);
  localparam int HALF_NS = 80;
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b1;
  end
  // Frame of n clocks; one sample before each rise and one at the end
  task automatic frame(input int n, output logic [64:0] sh);
    sh = '0;
    #1 cs_n_pin = 1'b0;
    #HALF_NS;
    for (int k = 0; k < n; k++) begin
      sclk_pin = 1'b0;
      #HALF_NS;
      sh = {sh[63:0], sdo_oe ? sdo_out : 1'bx};
      sclk_pin = 1'b1;
      #HALF_NS;
    end
    sh = {sh[63:0], sdo_oe ? sdo_out : 1'bx};
    cs_n_pin = 1'b1;
  endtask
endmodule

// file: rtl/sfc_frame_ctrl.sv
/*
  Frame, conversion and offset trim control of the converter.
  Assumes chip select and serial clock come from a host on pins,
  oversampled by clk_sys; the analog front end delivers each input
  already quantised in code steps as a signed word.
*/
`timescale 1ns/10ps

// Functional notes
// - Input sample is captured when chip select falls, opening a frame.
// - Serial clock edges alone step the conversion and shift the data.
// - Converted value is the positive input minus the negative input.
// - Result is a 14-bit two's-complement code, step is 2*Vref/2^14.
// - Zero to one step gives 0000, one to two steps gives 0001.
// - Input at or above reference minus one step saturates to 1FFF.
// - Input at or below minus that level saturates to 2000; next 2001 (code gives 2002 there and never 2001).
// - After power-up the converter sits in the acquire state.
// - A frame runs from chip select fall to rise; clocks count inside.
// - Data output is released while chip select is high.
// - Three states only, switched only by chip select and clock.
// - Eighteen falling edges finish a conversion; fewer give bad data.
// - Leading zero, then previous result MSB first per rise, then zeros.
// - Power-up trim takes 24 clocks; early chip select rise aborts.
// - Run-time trim takes 64 clocks; rise between 18 and 64 aborts.
module sfc_frame_ctrl
  import sfc_pkg::*;
#(
  parameter int IN_W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Serial link pins
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  output logic sdo_out,
  output logic sdo_oe,
  // Quantised analog inputs
  input wire logic signed [IN_W-1:0] positive_input,
  input wire logic signed [IN_W-1:0] negative_input,
  // Status
  output logic acquire_state,
  output logic convert_state,
  output logic offset_trim_state,
  output logic trim_done
);
  logic cs_act_s;
  logic sclk_unused;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic [2*IN_W-1:0] ain_s;
  logic signed [IN_W-1:0] pos_s;
  logic signed [IN_W-1:0] neg_s;
  logic signed [IN_W:0] diff;
  logic [RES_W-1:0] code_sat;
  logic fall_ev;
  logic rise_ev;
  logic [CNT_W-1:0] cnt_next;
  logic [RES_W-1:0] trial;
  logic [RES_W-1:0] sar_bit;

  sfc_state_t state_reg;
  logic [CNT_W-1:0] fall_cnt_reg;
  logic [RES_W-1:0] samp_reg;
  logic [RES_W-1:0] sar_reg;
  logic [RES_W-1:0] sar_bit_reg;
  logic [RES_W-1:0] result_reg;
  logic [RES_W-1:0] shift_reg;
  logic sdo_reg;
  logic first_frame_reg;
  logic trim_done_reg;

  // Pin synchronisers; chip select is synced active high so that its
  // idle level matches the cleared flops and no false edge follows reset
  sfc_sync #(.W(2)) u_link_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin_in({~cs_n_pin, sclk_pin}),
    .sync_out({cs_act_s, sclk_unused}),
    .rise_out({cs_fall, sclk_rise}),
    .fall_out({cs_rise, sclk_fall})
  );

  sfc_sync #(.W(2*IN_W)) u_ain_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin_in({positive_input, negative_input}),
    .sync_out(ain_s),
    .rise_out(),
    .fall_out()
  );

  assign pos_s = ain_s[2*IN_W-1:IN_W];
  assign neg_s = ain_s[IN_W-1:0];

  // Differential value with saturation
  always_comb begin
    diff = pos_s - neg_s;
    if (diff >= SAT_LIMIT) begin
      code_sat = CODE_POS_FS;
    end else if (diff <= -SAT_LIMIT) begin
      code_sat = CODE_NEG_FS;
    end else begin
      code_sat = diff[RES_W-1:0];
    end
  end

  // Link edges only count inside a frame
  assign fall_ev = sclk_fall & cs_act_s & ~cs_fall;
  assign rise_ev = sclk_rise & cs_act_s & ~cs_fall;
  assign cnt_next = (fall_cnt_reg == CNT_MAX) ? CNT_MAX
                    : fall_cnt_reg + CNT_ONE;

  // Falling edge counter
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fall_cnt_reg <= CNT_ZERO;
    end else if (cs_fall) begin
      fall_cnt_reg <= CNT_ZERO;
    end else if (fall_ev) begin
      fall_cnt_reg <= cnt_next;
    end
  end

  // State machine
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= SFC_ACQUIRE;
    end else begin
      case (state_reg)
        SFC_ACQUIRE: begin
          if (cs_fall) begin
            state_reg <= SFC_CONVERT;
          end else if (fall_ev && cnt_next > CONV_EDGES) begin
            state_reg <= SFC_OFFSET_TRIM;
          end
        end
        SFC_CONVERT: begin
          if (cs_rise) begin
            state_reg <= SFC_ACQUIRE;
          end else if (fall_ev && cnt_next == CONV_EDGES) begin
            state_reg <= SFC_ACQUIRE;
          end
        end
        SFC_OFFSET_TRIM: begin
          if (cs_rise) begin
            state_reg <= SFC_ACQUIRE;
          end else if (fall_ev && first_frame_reg &&
                       cnt_next == TRIM_PWRUP_EDGES) begin
            state_reg <= SFC_ACQUIRE;
          end else if (fall_ev && !first_frame_reg &&
                       cnt_next == TRIM_RUN_EDGES) begin
            state_reg <= SFC_ACQUIRE;
          end
        end
        default: begin
          state_reg <= SFC_ACQUIRE;
        end
      endcase
    end
  end

  // Trim completion and power-up frame tracking
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      trim_done_reg <= 1'b0;
      first_frame_reg <= 1'b1;
    end else begin
      if (state_reg == SFC_OFFSET_TRIM && fall_ev && !cs_rise &&
          ((first_frame_reg && cnt_next == TRIM_PWRUP_EDGES) ||
           (!first_frame_reg && cnt_next == TRIM_RUN_EDGES))) begin
        trim_done_reg <= 1'b1;
      end
      if (cs_rise) begin
        first_frame_reg <= 1'b0;
      end
    end
  end

  // Successive approximation on offset-binary code
  assign sar_bit = sar_bit_reg;
  assign trial = sar_reg | sar_bit;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      samp_reg <= CODE_ZERO;
      sar_reg <= CODE_ZERO;
      sar_bit_reg <= CODE_ZERO;
    end else if (cs_fall) begin
      samp_reg <= code_sat ^ CODE_SIGN;
      sar_reg <= CODE_ZERO;
      sar_bit_reg <= CODE_SIGN;
    end else if (fall_ev && state_reg == SFC_CONVERT &&
                 fall_cnt_reg < DATA_LAST_EDGE) begin
      if (trial <= samp_reg) begin
        sar_reg <= trial;
      end
      sar_bit_reg <= sar_bit_reg >> 1;
    end
  end

  // Result held for the next frame
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      result_reg <= CODE_ZERO;
    end else if (state_reg == SFC_CONVERT) begin
      if (fall_ev && cnt_next == CONV_EDGES) begin
        result_reg <= sar_reg ^ CODE_SIGN;
      end else if (cs_rise) begin
        result_reg <= sar_reg ^ CODE_SIGN;
      end
    end
  end

  // Output shifter
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= CODE_ZERO;
      sdo_reg <= 1'b0;
    end else if (cs_fall) begin
      shift_reg <= result_reg;
      sdo_reg <= 1'b0;
    end else if (rise_ev && fall_cnt_reg != CNT_ZERO) begin
      sdo_reg <= shift_reg[RES_W-1];
      shift_reg <= {shift_reg[RES_W-2:0], 1'b0};
    end
  end

  assign sdo_out = sdo_reg;
  assign sdo_oe = cs_act_s;
  assign acquire_state = (state_reg == SFC_ACQUIRE);
  assign convert_state = (state_reg == SFC_CONVERT);
  assign offset_trim_state = (state_reg == SFC_OFFSET_TRIM);
  assign trim_done = trim_done_reg;
endmodule

// file: rtl/sfc_pkg.sv
/*
  Constants for the serial frame control of a 14-bit differential
  successive-approximation converter.
  Assumes a single system clock that oversamples the serial link.
*/
package sfc_pkg;
  // Result format
  localparam int RES_W = 14;
  localparam logic [RES_W-1:0] CODE_MID = 14'h0000;
  localparam logic [RES_W-1:0] CODE_MID_P1 = 14'h0001;
  localparam logic [RES_W-1:0] CODE_POS_FS = 14'h1FFF;
  localparam logic [RES_W-1:0] CODE_NEG_FS = 14'h2000;
  localparam logic [RES_W-1:0] CODE_NEG_FS_P1 = 14'h2001;
  localparam logic [RES_W-1:0] CODE_SIGN = 14'h2000;
  localparam logic [RES_W-1:0] CODE_ZERO = 14'h0000;
  // Saturation limit in code steps (reference minus one step)
  localparam int SAT_LIMIT = 8191;
  // Frame edge counts
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
  localparam logic [CNT_W-1:0] CNT_MAX = 7'h7F;
  localparam logic [CNT_W-1:0] CONV_EDGES = 7'h12;
  localparam logic [CNT_W-1:0] TRIM_PWRUP_EDGES = 7'h18;
  localparam logic [CNT_W-1:0] TRIM_RUN_EDGES = 7'h40;
  localparam logic [CNT_W-1:0] DATA_LAST_EDGE = 7'h0E;
  // System clock frequency and period
  localparam int SYS_CLK_MHZ = 50;
  localparam int SYS_CLK_PERIOD_NS = 20;
  // Converter states
  typedef enum logic [1:0] {
    SFC_ACQUIRE,
    SFC_CONVERT,
    SFC_OFFSET_TRIM
  } sfc_state_t;
endpackage

// file: rtl/sfc_sync.sv
/*
  Two-stage synchroniser with edge detection for a vector of pins.
  Assumes the inputs are asynchronous to clk_sys.
*/
`timescale 1ns/10ps
module sfc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Pins
  input wire logic [W-1:0] pin_in,
  // Synchronised level and edges
  output logic [W-1:0] sync_out,
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign sync_out = sync_reg;
  assign rise_out = sync_reg & ~prev_reg;
  assign fall_out = ~sync_reg & prev_reg;
endmodule
